// File: core/fsxa_pkg.sv
package fsxa_pkg;
  // Wishbone register byte addresses
  localparam logic [3:0] FSXA_ADDR_PSC = 4'h0;
  localparam logic [3:0] FSXA_ADDR_PAGE = 4'h4;
  localparam logic [3:0] FSXA_ADDR_STAT = 4'h8;
  // Program store control fields
  localparam int FSXA_BIT_WE = 0;
  localparam int FSXA_BIT_EE = 1;
  localparam int FSXA_BIT_SP = 2;
  localparam logic [7:0] FSXA_PSC_MASK = 8'h07;
  localparam logic [7:0] FSXA_PSC_RST = 8'h00;
  localparam logic [7:0] FSXA_PAGE_RST = 8'h00;
  // Memory geometry
  localparam int FSXA_EXTERNAL_DATA_SPACE_WORDS = 4096;
  localparam int FSXA_EXTERNAL_DATA_SPACE_AW = 12;
  localparam int FSXA_FPAGE_AW = 9;
  localparam int FSXA_SP_AW = 7;
  // Page that holds the security bytes
  localparam logic [15:0] FSXA_SEC_PAGE_DEF = 16'hFE00;
  // Target encoding of an access
  typedef enum logic [1:0] {
    FSXA_TGT_EXTERNAL_DATA_SPACE = 2'b00,
    FSXA_TGT_MAIN = 2'b01,
    FSXA_TGT_SCRATCH = 2'b10
  } fsxa_tgt_t;
  localparam logic [1:0] FSXA_OP_NONE = 2'b00;
  localparam logic [1:0] FSXA_OP_PROG = 2'b01;
  localparam logic [1:0] FSXA_OP_ERASE = 2'b10;
  localparam logic [1:0] FSXA_OP_REFUSED = 2'b11;
endpackage

// File: core/fsxa_external_data_space.sv
`timescale 1ns/1ps
module fsxa_external_data_space
  import fsxa_pkg::*;
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [FSXA_EXTERNAL_DATA_SPACE_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  // On-chip data RAM, synchronous read
  logic [7:0] mem [FSXA_EXTERNAL_DATA_SPACE_WORDS];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// File: core/fsxa_top.sv
// Contract
// - Scratchpad select routes user flash code reads and writes to scratchpad sector.
// - Page erase only when erase enable and write enable are both set.
// - Enabled erase turns a flash write into erase of the addressed page.
// - Write enable steers external-move writes to flash byte programming.
// - Provide 4 KB on-chip RAM in the external data space.
// - Index form address is page-select high byte joined with R0/R1.
// - Without flash enables every external-move access targets the data space.
// - Data-pointer form uses the full 16-bit pointer as address.
// - Erase of the security-byte page is always refused; the code refuses it only with scratchpad select clear.
`timescale 1ns/1ps
module fsxa_top
  import fsxa_pkg::*;
#(
  parameter logic [15:0] SEC_PAGE = FSXA_SEC_PAGE_DEF
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core external-move request
  input wire logic mv_req_i,
  input wire logic mv_we_i,
  input wire logic mv_idx_i,
  input wire logic [15:0] mv_data_pointer_register_i,
  input wire logic [7:0] mv_rx_i,
  input wire logic [7:0] mv_wdata_i,
  output logic mv_ack_o,
  output logic [7:0] mv_rdata_o,
  // Core code read
  input wire logic cr_req_i,
  input wire logic [15:0] cr_addr_i,
  output logic cr_ack_o,
  output logic [7:0] cr_rdata_o,
  // Flash array side
  output logic fl_req_o,
  output logic [1:0] fl_op_o,
  output logic fl_scratch_o,
  output logic [15:0] fl_addr_o,
  output logic [7:0] fl_wdata_o,
  input wire logic fl_done_i,
  input wire logic [7:0] fl_rdata_i
);
  logic [7:0] psc_q;
  logic [7:0] page_q;
  logic [1:0] last_op_q;
  logic [15:0] ea;
  fsxa_tgt_t tgt;
  logic [1:0] fop;
  logic wb_hit;
  logic xr_we;
  logic [7:0] xr_rdata;

  typedef enum logic [1:0] {
    FSXA_IDLE = 2'b00,
    FSXA_XRD = 2'b01,
    FSXA_FLW = 2'b10,
    FSXA_DONE = 2'b11
  } fsxa_st_t;
  fsxa_st_t st_q;
  logic code_q;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Effective address of an external-move access
  always_comb begin
    if (mv_idx_i) begin
      ea = {page_q, mv_rx_i};
    end else begin
      ea = mv_data_pointer_register_i;
    end
  end

  // Target and flash operation; reads always go to RAM
  always_comb begin
    tgt = FSXA_TGT_EXTERNAL_DATA_SPACE;
    fop = FSXA_OP_NONE;
    if (mv_we_i && psc_q[FSXA_BIT_WE]) begin
      tgt = psc_q[FSXA_BIT_SP] ? FSXA_TGT_SCRATCH : FSXA_TGT_MAIN;
      if (psc_q[FSXA_BIT_EE]) begin
        // Security page is guarded in main sector only
        if (!psc_q[FSXA_BIT_SP] && ea[15:FSXA_FPAGE_AW] == SEC_PAGE[15:FSXA_FPAGE_AW]) begin
          fop = FSXA_OP_REFUSED;
        end else begin
          fop = FSXA_OP_ERASE;
        end
      end else begin
        fop = FSXA_OP_PROG;
      end
    end
  end

  // Control registers; program store control keeps only its low three bits, page keeps all eight
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psc_q <= FSXA_PSC_RST;
      page_q <= FSXA_PAGE_RST;
    end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == FSXA_ADDR_PSC) begin
        psc_q <= wb_dat_i[7:0] & FSXA_PSC_MASK;
      end else if (wb_adr_i == FSXA_ADDR_PAGE) begin
        page_q <= wb_dat_i[7:0];
      end
    end
  end

  // Bus answer one cycle after the request; unmapped reads zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          FSXA_ADDR_PSC: wb_dat_o <= {24'h00_0000, psc_q};
          FSXA_ADDR_PAGE: wb_dat_o <= {24'h00_0000, page_q};
          FSXA_ADDR_STAT: wb_dat_o <= {28'h000_0000, st_q, last_op_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign xr_we = (st_q == FSXA_IDLE) && mv_req_i && mv_we_i && tgt == FSXA_TGT_EXTERNAL_DATA_SPACE;

  fsxa_external_data_space u_external_data_space (
    .clk_i(clk_i),
    .we_i(xr_we),
    .addr_i(ea[FSXA_EXTERNAL_DATA_SPACE_AW-1:0]),
    .wdata_i(mv_wdata_i),
    .rdata_o(xr_rdata)
  );

  // Access sequencer; moves win over code reads
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= FSXA_IDLE;
      code_q <= 1'b0;
      mv_ack_o <= 1'b0;
      cr_ack_o <= 1'b0;
      mv_rdata_o <= 8'h00;
      cr_rdata_o <= 8'h00;
      fl_req_o <= 1'b0;
      fl_op_o <= FSXA_OP_NONE;
      fl_scratch_o <= 1'b0;
      fl_addr_o <= 16'h0000;
      fl_wdata_o <= 8'h00;
      last_op_q <= FSXA_OP_NONE;
    end else begin
      mv_ack_o <= 1'b0;
      cr_ack_o <= 1'b0;
      case (st_q)
        FSXA_IDLE: begin
          if (mv_req_i) begin
            if (tgt == FSXA_TGT_EXTERNAL_DATA_SPACE) begin
              st_q <= mv_we_i ? FSXA_DONE : FSXA_XRD;
              if (mv_we_i) begin
                mv_ack_o <= 1'b1;
              end
            end else if (fop == FSXA_OP_REFUSED) begin
              last_op_q <= fop;
              mv_ack_o <= 1'b1; // Refused erase completes silently
              st_q <= FSXA_DONE;
            end else begin
              fl_req_o <= 1'b1;
              fl_op_o <= fop;
              fl_scratch_o <= (tgt == FSXA_TGT_SCRATCH);
              fl_addr_o <= ea;
              fl_wdata_o <= mv_wdata_i;
              last_op_q <= fop;
              code_q <= 1'b0;
              st_q <= FSXA_FLW;
            end
          end else if (cr_req_i) begin
            fl_req_o <= 1'b1;
            fl_op_o <= FSXA_OP_NONE;
            fl_scratch_o <= psc_q[FSXA_BIT_SP];
            fl_addr_o <= cr_addr_i;
            code_q <= 1'b1;
            st_q <= FSXA_FLW;
          end
        end
        FSXA_XRD: begin
          mv_rdata_o <= xr_rdata;
          mv_ack_o <= 1'b1;
          st_q <= FSXA_DONE;
        end
        FSXA_FLW: begin
          if (fl_done_i) begin
            fl_req_o <= 1'b0;
            if (code_q) begin
              cr_rdata_o <= fl_rdata_i;
              cr_ack_o <= 1'b1;
            end else begin
              mv_ack_o <= 1'b1;
            end
            st_q <= FSXA_DONE;
          end
        end
        FSXA_DONE: begin
          // Gap cycle so the core drops its request
          st_q <= FSXA_IDLE;
        end
        default: st_q <= FSXA_IDLE;
      endcase
    end
  end

  // Erase never starts without both enables
  chk_erase_needs_we: assert property (@(posedge clk_i) disable iff (rst_i)
    (fl_req_o && fl_op_o == FSXA_OP_ERASE) |-> (psc_q[FSXA_BIT_WE] && psc_q[FSXA_BIT_EE]))
    else $error("erase issued without both enables");

  // Security page never reaches the main sector of the array as an erase
  chk_sec_page_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(fl_req_o) && fl_op_o == FSXA_OP_ERASE && !fl_scratch_o
      |-> fl_addr_o[15:FSXA_FPAGE_AW] != SEC_PAGE[15:FSXA_FPAGE_AW])
    else $error("security page erase issued");

  // Unused control bits can never be stored
  chk_upper_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (psc_q & ~FSXA_PSC_MASK) == 8'h00)
    else $error("control upper bits nonzero");

  // Write enable alone turns a write into byte programming
  chk_prog_on_we: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && mv_req_i && mv_we_i && psc_q == 8'h01)
      |=> fl_req_o && fl_op_o == FSXA_OP_PROG)
    else $error("write not steered to flash program");

  // Both enables turn a write into a page erase
  chk_erase_on_ee: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && mv_req_i && mv_we_i && psc_q == 8'h03
      && ea[15:FSXA_FPAGE_AW] != SEC_PAGE[15:FSXA_FPAGE_AW])
      |=> fl_req_o && fl_op_o == FSXA_OP_ERASE)
    else $error("enabled erase not issued");

  // Refused erases never load the flash address, so they are left out here
  chk_index_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && mv_req_i && mv_idx_i && psc_q[FSXA_BIT_WE] && mv_we_i && fop != FSXA_OP_REFUSED)
      |=> fl_addr_o == {$past(page_q), $past(mv_rx_i)})
    else $error("index address not page joined");
  chk_data_pointer_register_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && mv_req_i && !mv_idx_i && psc_q[FSXA_BIT_WE] && mv_we_i && fop != FSXA_OP_REFUSED)
      |=> fl_addr_o == $past(mv_data_pointer_register_i))
    else $error("pointer address not used");

  // Code reads follow the scratchpad select
  chk_code_scratch: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && !mv_req_i && cr_req_i) |=> fl_req_o && fl_scratch_o == $past(psc_q[FSXA_BIT_SP]))
    else $error("code read sector wrong");

  // Without write enable a move stays in the data space
  chk_default_external_data_space: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && mv_req_i && !psc_q[FSXA_BIT_WE]) |=> !fl_req_o)
    else $error("move left data space without enable");

  // Steps of a flash move: taken in idle, array busy, answer after done
  sequence fsxa_fl_write_taken;
    st_q == FSXA_IDLE && mv_req_i && mv_we_i && psc_q[FSXA_BIT_WE] && fop != FSXA_OP_REFUSED;
  endsequence
  sequence fsxa_fl_busy;
    fl_req_o && st_q == FSXA_FLW && !mv_ack_o;
  endsequence
  sequence fsxa_fl_finish;
    st_q == FSXA_FLW && fl_done_i;
  endsequence
  sequence fsxa_fl_answer;
    !fl_req_o && st_q == FSXA_DONE && (mv_ack_o || cr_ack_o);
  endsequence
  sequence fsxa_ram_read_taken;
    st_q == FSXA_IDLE && mv_req_i && !mv_we_i;
  endsequence

  // Enabled write reaches the array and is not answered early
  chk_flash_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    fsxa_fl_write_taken |=> fsxa_fl_busy)
    else $error("flash write not started");

  // Array done closes the request and answers the core
  chk_flash_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    fsxa_fl_finish |=> fsxa_fl_answer)
    else $error("flash done not answered");

  // A redirected write must never also land in the RAM
  chk_ram_write_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    xr_we |-> !psc_q[FSXA_BIT_WE])
    else $error("flash write also stored in RAM");

  // Refused erase is answered at once and never reaches the array
  chk_refused_silent: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && mv_req_i && fop == FSXA_OP_REFUSED) |=> mv_ack_o && !fl_req_o)
    else $error("refused erase not answered quietly");

  // Scratchpad select steers enabled writes to the scratchpad sector
  chk_scratch_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && mv_req_i && mv_we_i && psc_q[FSXA_BIT_WE] && psc_q[FSXA_BIT_SP])
      |=> fl_req_o && fl_scratch_o)
    else $error("scratchpad write sent to main sector");

  // Erase enable without write enable starts nothing
  chk_ee_alone_ram: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == FSXA_IDLE && mv_req_i && psc_q[FSXA_BIT_EE] && !psc_q[FSXA_BIT_WE]) |=> !fl_req_o)
    else $error("erase enable alone reached flash");

  // RAM reads answer after one internal read cycle
  chk_ram_read_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    fsxa_ram_read_taken |=> st_q == FSXA_XRD ##1 mv_ack_o)
    else $error("RAM read not answered in time");
endmodule

// File: verification/fsxa_flash_model.sv
`timescale 1ns/1ps
module fsxa_flash_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic scratch_i,
  input wire logic [15:0] addr_i,
  output logic done_o,
  output logic [7:0] rdata_o
);
  logic [1:0] wait_q;
  // Slow array, done pulses on the fourth cycle of a request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 2'h0;
      done_o <= 1'b0;
    end else if (done_o || !req_i) begin
      wait_q <= 2'h0;
      done_o <= 1'b0;
    end else begin
      wait_q <= wait_q + 2'h1;
      done_o <= (wait_q == 2'h2);
    end
  end
  // Data valid with done only; toggles so a stale sample shows
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i && wait_q == 2'h2) begin
      rdata_o <= addr_i[7:0] ^ {scratch_i, 7'h00};
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// File: verification/flash_store_and_external_data_space_access_bench.sv
`timescale 1ns/1ps
module flash_store_and_external_data_space_access_bench;
  import fsxa_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mv_req_i, mv_we_i, mv_idx_i, mv_ack_o;
  logic cr_req_i, cr_ack_o, fl_req_o, fl_scratch_o, fl_done_i, fs, fsc;
  logic [1:0] fl_op_o, fo;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [7:0] mv_rx_i, mv_wdata_i, mv_rdata_o, cr_rdata_o, fl_wdata_o, fl_rdata_i, q, fw;
  logic [15:0] mv_data_pointer_register_i, cr_addr_i, fl_addr_o, fa;
  logic [31:0] wb_dat_i, wb_dat_o, e;
  logic [31:0] tb [5];
  int err_count, cmp_count;
  fsxa_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .mv_req_i, .mv_we_i, .mv_idx_i, .mv_data_pointer_register_i, .mv_rx_i, .mv_wdata_i,
    .mv_ack_o, .mv_rdata_o, .cr_req_i, .cr_addr_i, .cr_ack_o, .cr_rdata_o, .fl_req_o, .fl_op_o,
    .fl_scratch_o, .fl_addr_o, .fl_wdata_o, .fl_done_i, .fl_rdata_i);
  fsxa_flash_model u_fl (.clk_i, .rst_i, .req_i(fl_req_o), .scratch_i(fl_scratch_o),
    .addr_i(fl_addr_o), .done_o(fl_done_i), .rdata_o(fl_rdata_i));
  // Free running 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Waits for a move or code read answer, noting any flash request
  task automatic wt();
    int n;
    n = 0;
    {fs, fsc, fo, fa, fw} = '0;
    do begin
      @(posedge clk_i);
      n++;
      if (fl_req_o === 1'b1) begin
        {fs, fsc, fo, fa, fw} = {1'b1, fl_scratch_o, fl_op_o, fl_addr_o, fl_wdata_o};
      end
    end while (mv_ack_o !== 1'b1 && cr_ack_o !== 1'b1 && n < 60);
    if (n >= 60) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 60);
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
    if (n >= 60) begin
      err_count++;
      close_out();
    end
  endtask
  // Index form gets an inverted pointer so a wrong address source shows
  task automatic mv(input logic w, input logic ix, input logic [15:0] a, input logic [7:0] d);
    {mv_req_i, mv_we_i, mv_idx_i, mv_wdata_i, mv_rx_i} <= {1'b1, w, ix, d, a[7:0]};
    mv_data_pointer_register_i <= ix ? ~a : a;
    wt();
    q = mv_rdata_o;
    mv_req_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cr(input logic [15:0] a);
    cr_req_i <= 1'b1;
    cr_addr_i <= a;
    wt();
    q = cr_rdata_o;
    cr_req_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 8'h01, 32'h0000_0000};
    {mv_req_i, mv_we_i, mv_idx_i, mv_data_pointer_register_i, mv_rx_i, mv_wdata_i} = '0;
    {cr_req_i, cr_addr_i, err_count, cmp_count} = '0;
    tb = '{32'h0102_0009, 32'h0203_0000, 32'h0304_000A, 32'h03FE_1000, 32'h0500_100D};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, FSXA_ADDR_PSC, 8'h00);
    check("psc_reset", q, FSXA_PSC_RST);
    wb(1'b0, FSXA_ADDR_PAGE, 8'h00);
    check("page_reset", q, FSXA_PAGE_RST);
    wb(1'b1, FSXA_ADDR_PSC, 8'hFF);
    wb(1'b0, FSXA_ADDR_PSC, 8'h00);
    check("psc_mask", q, 8'h07);
    wb(1'b1, FSXA_ADDR_PSC, 8'h00);
    wb(1'b1, FSXA_ADDR_PAGE, 8'h12);
    mv(1'b1, 1'b1, 16'h1234, 8'hA5);
    check("ram_wr_no_flash", fs, 1'b0);
    mv(1'b0, 1'b0, 16'h1234, 8'h00);
    check("ptr_rd", q, 8'hA5);
    mv(1'b1, 1'b0, 16'h0FFF, 8'h5C);
    wb(1'b1, FSXA_ADDR_PAGE, 8'h0F);
    mv(1'b0, 1'b1, 16'h0FFF, 8'h00);
    check("ram_top", q, 8'h5C);
    // Five flash enable mixes: psc, address, then expected request
    for (int i = 0; i < 5; i++) begin
      e = tb[i];
      wb(1'b1, FSXA_ADDR_PSC, e[31:24]);
      mv(1'b1, 1'b0, e[23:8], e[19:12]);
      check("fl_req_kind", {fs, fsc, fo}, e[3:0]);
      check("fl_adr", fa, e[3] ? e[23:8] : 16'h0000);
      if (e[0]) check("fl_dat", fw, e[19:12]);
    end
    // Status shows idle and the last issued operation
    wb(1'b0, FSXA_ADDR_STAT, 8'h00);
    check("stat_last_op", q, {14'h0000, FSXA_OP_PROG});
    wb(1'b1, FSXA_ADDR_PSC, 8'h00);
    mv(1'b0, 1'b0, 16'h0300, 8'h00);
    check("ee_only_to_ram", q, 8'h30);
    wb(1'b1, FSXA_ADDR_PSC, 8'h04);
    cr(16'h0020);
    check("cr_scratch", {fs, fsc, fo, q}, 16'h0CA0);
    wb(1'b1, FSXA_ADDR_PSC, 8'h00);
    cr(16'h1234);
    check("cr_main", {fs, fsc, fo, q}, 16'h0834);
    wb(1'b0, 4'hC, 8'h00);
    check("unmapped_rd", q, 8'h00);
    close_out();
  end
endmodule
